//--- sim/cpr_regs_tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t got %h exp %h", $time, (got), (exp)); end end
module cpr_regs_tb_top
  import cpr_pkg::*;
;
  typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} cpr_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, prog_addr, data_addr, vector_addr, icache_control, icache_op_address, red_prog_addr;
  logic hreadyout, hresp, supervisor, master_mode;
  logic [2:0] prog_fc, data_fc, int_mask;
  logic [1:0] trace_mode;
  logic [4:0] cond_flags;
  int err_total = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  cpr_row_t rows [0:19] = '{
    '{8'h00, 32'h1234_5678, 8'h00, 32'h1234_5678},
    '{8'h1C, 32'hA5A5_5A5A, 8'h1C, 32'hA5A5_5A5A},
    '{8'h20, 32'h8765_4321, 8'h20, 32'h8765_4321},
    '{8'h3C, 32'hCAFE_0000, 8'h64, 32'hCAFE_0000},
    '{8'h40, 32'hFF00_1000, 8'h40, 32'hFF00_1000},
    '{8'h44, 32'h0000_0004, 8'h40, 32'hFF00_1004},
    '{8'h4C, 32'h0001_0000, 8'h4C, 32'h0001_0000},
    '{8'h50, 32'hFFFF_FFFF, 8'h50, 32'h0000_0007},
    '{8'h54, 32'h0000_0005, 8'h54, 32'h0000_0005},
    '{8'h58, 32'hDEAD_BEEF, 8'h58, 32'hDEAD_BEEF},
    '{8'h5C, 32'h1357_9BDF, 8'h5C, 32'h1357_9BDF},
    '{8'h60, 32'h0000_2000, 8'h60, 32'h0000_2000},
    '{8'h68, 32'h0000_3000, 8'h68, 32'h0000_3000},
    '{8'h88, 32'h0000_0001, 8'h88, 32'h0000_0000},
    '{8'h48, 32'hFFFF_FFFF, 8'h3C, 32'h0000_3000},
    '{8'h48, 32'h0000_2700, 8'h48, 32'h0000_2700},
    '{8'h7C, 32'h0BAD_F00D, 8'h04, 32'h0BAD_F00D},
    '{8'h80, 32'h0000_0100, 8'h80, 32'h0000_5778},
    '{8'h84, 32'h0000_0002, 8'h84, 32'h0001_0008},
    '{8'h6C, 32'h0000_0E42, 8'h74, 32'h0000_0067}
  };

  always #5 clk = ~clk;

  cpr_regs #(.REDUCED(1'b0)) cpr_regs_i (.CORE_CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PROG_ADDR(prog_addr), .PROG_FC(prog_fc), .DATA_ADDR(data_addr),
    .DATA_FC(data_fc), .VECTOR_ADDR(vector_addr), .TRACE_MODE(trace_mode), .SUPERVISOR(supervisor),
    .MASTER_MODE(master_mode), .INT_MASK(int_mask), .COND_FLAGS(cond_flags), .ICACHE_CONTROL(icache_control),
    .ICACHE_OP_ADDRESS(icache_op_address));

  // Narrow-address variant shares the bus, only its program address is watched
  cpr_regs #(.REDUCED(1'b1)) cpr_regs_red_i (.CORE_CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(),
    .HREADYOUT(), .HRESP(), .PROG_ADDR(red_prog_addr), .PROG_FC(), .DATA_ADDR(), .DATA_FC(),
    .VECTOR_ADDR(), .TRACE_MODE(), .SUPERVISOR(), .MASTER_MODE(), .INT_MASK(), .COND_FLAGS(),
    .ICACHE_CONTROL(), .ICACHE_OP_ADDRESS());

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      err_total++;
      complete_run();
    end
  end

  // One single transfer; ready and read data taken at the completing rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    q = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    `CHK(q, exp)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    htrans <= 2'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK({supervisor, int_mask, hreadyout}, 5'h1F)
    @(posedge clk);
    arst_n <= 1'b1;
    settle(2);
    `CHK({prog_fc, data_fc}, {FC_SUP_PROG, FC_SUP_DATA})
    `CHK({trace_mode, master_mode}, 3'h0)
    rd(OFF_SR, 32'h0000_2700);
    rd(OFF_OPCTL, 32'h0000_0002);
    rd(OFF_VBR, 32'h0000_0000);
  endtask

  initial
  begin
    do_reset();
    $display("test reset finished");
    for (int i = 0; i < 20; i++)
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rows[i].ex);
    end
    settle(2);
    `CHK(prog_addr, 32'hFF00_1004)
    `CHK(red_prog_addr, 32'h0000_1004)
    `CHK(vector_addr, 32'h0001_0008)
    `CHK(data_addr, 32'h0000_5778)
    `CHK(icache_op_address, 32'h1357_9BDF)
    $display("test table finished");
    wr(OFF_SR, 32'h0000_F71F);
    settle(2);
    `CHK({trace_mode, master_mode, int_mask, cond_flags}, 11'h7FF)
    wr(OFF_SR, 32'h0000_2000);
    wr(OFF_OPCTL, 32'h0000_0000);
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24, 32'h0000_0000);
    wr(8'h08, 32'h1234_56AB);
    rd(8'h08, 32'h0000_00AB);
    wr(OFF_OPCTL, 32'h0000_0001);
    wr(8'h24, 32'h0000_8001);
    rd(8'h24, 32'hFFFF_8001);
    wr(OFF_OPCTL, 32'h0000_0006);
    settle(2);
    `CHK(data_fc, 3'h7)
    wr(OFF_OPCTL, 32'h0000_000E);
    settle(2);
    `CHK(data_fc, 3'h5)
    wr(OFF_OPCTL, 32'h0000_0002);
    $display("test sizes finished");
    wr(OFF_GPR, 32'h0000_0001);
    wr(OFF_ADD, 32'hFFFF_FFFF);
    rd(OFF_GPR, 32'h0000_0000);
    rd(OFF_SR, 32'h0000_2015);
    settle(2);
    `CHK(cond_flags, 5'h15)
    $display("test flags finished");
    wr(OFF_SR, 32'h0000_0000);
    settle(2);
    `CHK({supervisor, prog_fc, data_fc}, {1'b0, FC_USER_PROG, FC_USER_DATA})
    wr(OFF_VBR, 32'hFFFF_FFFF);
    wr(OFF_ICACHE_CONTROL, 32'h0000_0000);
    wr(OFF_SR, 32'hFFFF_FFFF);
    rd(OFF_SR, 32'h0000_001F);
    rd(OFF_VBR, 32'h0000_0000);
    wr(OFF_A7, 32'h0000_4444);
    rd(OFF_A7, 32'h0000_4444);
    settle(2);
    `CHK(vector_addr, 32'h0001_0008)
    `CHK(icache_control, 32'hDEAD_BEEF)
    `CHK(supervisor, 1'b0)
    $display("test user level finished");
    do_reset();
    $display("test second reset finished");
    complete_run();
  end
endmodule // cpr_regs_tb_top

//--- verilog/cpr_agu.sv
`timescale 1ns/1ns
module cpr_agu
  import cpr_pkg::*;
#(
  parameter logic REDUCED = 1'b0
)
(
  input wire logic [31:0] pc,
  input wire logic [31:0] disp,
  input wire logic [31:0] idx_val,
  input wire logic idx_long,
  input wire logic [1:0] scale,
  input wire logic [31:0] vector_table_base,
  input wire logic [7:0] vec,
  input wire logic sup,
  input wire logic alt_en,
  input wire logic alt_dst,
  input wire logic [2:0] source_space_code,
  input wire logic [2:0] dfc,
  output logic [31:0] ea,
  output logic [31:0] vec_addr,
  output logic [31:0] prog_addr,
  output logic [31:0] data_addr,
  output logic [2:0] prog_fc,
  output logic [2:0] data_fc
);
  logic [31:0] iv;

  // Reduced variant drives only the low address lines
  function automatic logic [31:0] narrow(input logic [31:0] a);
    return REDUCED ? {8'h00, a[23:0]} : a;
  endfunction

  assign iv = idx_long ? idx_val : {{16{idx_val[15]}}, idx_val[15:0]};
  assign ea = disp + (iv << scale);
  assign vec_addr = narrow(vector_table_base + {22'h00_0000, vec, 2'h0});
  assign prog_addr = narrow(pc);
  assign data_addr = narrow(ea);
  assign prog_fc = sup ? FC_SUP_PROG : FC_USER_PROG;
  assign data_fc = alt_en ? (alt_dst ? dfc : source_space_code) : (sup ? FC_SUP_DATA : FC_USER_DATA);
endmodule // cpr_agu

//--- verilog/cpr_pkg.sv
package cpr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_GPR = 8'h00;
  localparam logic [7:0] OFF_A7 = 8'h3C;
  localparam logic [7:0] OFF_PC = 8'h40;
  localparam logic [7:0] OFF_PC_ADV = 8'h44;
  localparam logic [7:0] OFF_SR = 8'h48;
  localparam logic [7:0] OFF_VBR = 8'h4C;
  localparam logic [7:0] OFF_SFC = 8'h50;
  localparam logic [7:0] OFF_DFC = 8'h54;
  localparam logic [7:0] OFF_ICACHE_CONTROL = 8'h58;
  localparam logic [7:0] OFF_ICACHE_OP_ADDRESS = 8'h5C;
  localparam logic [7:0] OFF_USP = 8'h60;
  localparam logic [7:0] OFF_ISP = 8'h64;
  localparam logic [7:0] OFF_MSP = 8'h68;
  localparam logic [7:0] OFF_OPCTL = 8'h6C;
  localparam logic [7:0] OFF_ADD = 8'h70;
  localparam logic [7:0] OFF_FIELD = 8'h74;
  localparam logic [7:0] OFF_QLO = 8'h78;
  localparam logic [7:0] OFF_QHI = 8'h7C;
  localparam logic [7:0] OFF_EA = 8'h80;
  localparam logic [7:0] OFF_VEC = 8'h84;
  // Status word fields
  localparam int SR_T1 = 15;
  localparam int SR_T0 = 14;
  localparam int SR_S = 13;
  localparam int SR_M = 12;
  localparam int SR_IPL_LO = 8;
  localparam int SR_X = 4;
  localparam int SR_Z = 2;
  localparam logic [15:0] SR_IMPL = 16'hF71F;
  localparam logic [15:0] SR_RST = 16'h2700;
  // Operation control fields
  localparam int OPC_SIZE_LO = 0;
  localparam int OPC_ALT = 2;
  localparam int OPC_ALT_DST = 3;
  localparam int OPC_FOFF_LO = 4;
  localparam int OPC_FWID_LO = 9;
  localparam int OPC_IDX_LO = 14;
  localparam int OPC_IDX_LONG = 18;
  localparam int OPC_SCALE_LO = 19;
  localparam logic [31:0] OPC_RST = 32'h0000_0002;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [3:0] A7_NUM = 4'hF;
  // Function codes
  localparam logic [2:0] FC_USER_DATA = 3'h1;
  localparam logic [2:0] FC_USER_PROG = 3'h2;
  localparam logic [2:0] FC_SUP_DATA = 3'h5;
  localparam logic [2:0] FC_SUP_PROG = 3'h6;

  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2, SZ_QUAD = 2'h3} cpr_size_t;
  typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_WR = 4'h2, ST_RDW = 4'h4, ST_RDD = 4'h8} cpr_bus_t;
endpackage

//--- verilog/cpr_regs.sv
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// Contract
// - Sixteen 32-bit general registers, eight data and eight address, all usable as index.
// - Data registers take bit, bit field, byte, word, long and register-pair quad operands.
// - Address registers take word and long writes only, never byte.
// - Address register seven is user stack, or active interrupt/master stack in supervisor.
// - Status word holds five condition flags set from the last operation result.
// - User level sees only the low status byte, the condition flag byte.
// - Supervisor level reaches the whole status word including three-bit interrupt mask.
// - Status word holds two trace bits, privilege bit and stack-select bit.
// - Vector base register plus vector displacement forms the vector fetch address.
// - Source and destination 3-bit space codes set operand function codes explicitly.
// - Function codes generated automatically select user or supervisor program or data spaces.
// - Program counter holds next instruction address, stepped or loaded as needed.
// - Two 32-bit icache registers: control and operation address.
// - Reduced variant drives 24-bit addresses, full variant 32-bit addresses.
module cpr_regs
  import cpr_pkg::*;
#(
  parameter logic REDUCED = 1'b0
)
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] PROG_ADDR,
  output logic [2:0] PROG_FC,
  output logic [31:0] DATA_ADDR,
  output logic [2:0] DATA_FC,
  output logic [31:0] VECTOR_ADDR,
  output logic [1:0] TRACE_MODE,
  output logic SUPERVISOR,
  output logic MASTER_MODE,
  output logic [2:0] INT_MASK,
  output logic [4:0] COND_FLAGS,
  output logic [31:0] ICACHE_CONTROL,
  output logic [31:0] ICACHE_OP_ADDRESS
);
  cpr_bus_t st_q;
  cpr_bus_t st_d;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] gpr_q [15];
  logic [31:0] gpr_v [16];
  logic [31:0] user_stack_pointer_q;
  logic [31:0] interrupt_stack_pointer_q;
  logic [31:0] master_stack_pointer_q;
  logic [31:0] pc_q;
  logic [31:0] vector_table_base_q;
  logic [2:0] source_space_code_q;
  logic [2:0] destination_space_code_q;
  logic [31:0] icache_control_q;
  logic [31:0] icache_op_address_q;
  logic [31:0] opctl_q;
  logic [31:0] disp_q;
  logic [7:0] vec_q;
  logic [31:0] prog_addr_q;
  logic [31:0] data_addr_q;
  logic [31:0] vec_addr_q;
  logic [2:0] prog_fc_q;
  logic [2:0] data_fc_q;
  logic [15:0] processor_status_word;
  logic [31:0] sum;
  logic [31:0] ea;
  logic [31:0] vec_addr;
  logic [31:0] prog_addr;
  logic [31:0] data_addr;
  logic [2:0] prog_fc;
  logic [2:0] data_fc;
  logic [31:0] rd_raw;
  logic [31:0] active_supervisor_stack_pointer;
  logic [31:0] a7_v;

  wire accept = HSEL && HREADY && HTRANS[1];
  wire we = st_q == ST_WR;
  wire sup = processor_status_word[SR_S];
  wire master = processor_status_word[SR_M];
  wire cpr_size_t op_size = cpr_size_t'(opctl_q[OPC_SIZE_LO +: 2]);
  wire [3:0] d_idx = {1'b0, opctl_q[OPC_IDX_LO +: 3]};
  wire [3:0] x_idx = opctl_q[OPC_IDX_LO +: 4];
  wire [3:0] pair = {1'b0, opctl_q[OPC_IDX_LO + 1 +: 2], 1'b0};
  wire [4:0] foff = opctl_q[OPC_FOFF_LO +: 5];
  wire [4:0] fwid = opctl_q[OPC_FWID_LO +: 5];
  wire [31:0] fmask = 32'hFFFF_FFFF >> (5'h1F - fwid);
  wire [31:0] field_val = (gpr_v[d_idx] >> foff) & fmask;

  wire gpr_hit = we && addr_q[7:6] == OFF_GPR[7:6];
  wire add_hit = we && addr_q == OFF_ADD;
  wire qlo_hit = we && addr_q == OFF_QLO;
  wire qhi_hit = we && addr_q == OFF_QHI;
  wire sup_we = we && sup;
  wire [3:0] gw_num = gpr_hit ? addr_q[5:2] : qhi_hit ? (pair | 4'h1) : qlo_hit ? pair : d_idx;
  wire [31:0] gw_src = add_hit ? sum : HWDATA;
  wire cpr_size_t gw_sz = (qlo_hit || qhi_hit) ? SZ_LONG : op_size;
  wire gw_is_addr = gw_num[3];
  wire gw_en = (gpr_hit || add_hit || qlo_hit || qhi_hit) && !(gw_is_addr && gw_sz == SZ_BYTE);
  wire [31:0] gw_val = merge(gpr_v[gw_num], gw_src, gw_sz, gw_is_addr);
  wire a7_we = gw_en && gw_num == A7_NUM;

  wire usp_we = (a7_we && !sup) || (sup_we && addr_q == OFF_USP);
  wire isp_we = (a7_we && sup && !master) || (sup_we && addr_q == OFF_ISP);
  wire msp_we = (a7_we && sup && master) || (sup_we && addr_q == OFF_MSP);
  wire priv_reg = addr_q == OFF_VBR || addr_q == OFF_SFC || addr_q == OFF_DFC || addr_q == OFF_ICACHE_CONTROL
    || addr_q == OFF_ICACHE_OP_ADDRESS || addr_q == OFF_USP || addr_q == OFF_ISP || addr_q == OFF_MSP;
  wire [31:0] rd_val = (priv_reg && !sup) ? REG_RST : rd_raw;

  // Sized write into a data or address register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
    input cpr_size_t sz, input logic is_a);
    logic [31:0] r;
    r = nv;
    if (is_a && sz == SZ_WORD)
      r = {{16{nv[15]}}, nv[15:0]};
    else if (!is_a && sz == SZ_WORD)
      r = {old[31:16], nv[15:0]};
    else if (!is_a && sz == SZ_BYTE)
      r = {old[31:8], nv[7:0]};
    return r;
  endfunction

  // A7 follows privilege and stack select
  assign active_supervisor_stack_pointer = master ? master_stack_pointer_q : interrupt_stack_pointer_q;
  assign a7_v = sup ? active_supervisor_stack_pointer : user_stack_pointer_q;

  always_comb
  begin
    for (int i = 0; i < 15; i++)
      gpr_v[i] = gpr_q[i];
    gpr_v[15] = a7_v;
  end

  always_comb
  begin
    rd_raw = REG_RST;
    if (addr_q[7:6] == OFF_GPR[7:6])
      rd_raw = gpr_v[addr_q[5:2]];
    else
      case (addr_q)
        OFF_PC: rd_raw = pc_q;
        OFF_SR: rd_raw = sup ? {16'h0000, processor_status_word} : {24'h00_0000, processor_status_word[7:0]};
        OFF_VBR: rd_raw = vector_table_base_q;
        OFF_SFC: rd_raw = {29'h0000_0000, source_space_code_q};
        OFF_DFC: rd_raw = {29'h0000_0000, destination_space_code_q};
        OFF_ICACHE_CONTROL: rd_raw = icache_control_q;
        OFF_ICACHE_OP_ADDRESS: rd_raw = icache_op_address_q;
        OFF_USP: rd_raw = user_stack_pointer_q;
        OFF_ISP: rd_raw = interrupt_stack_pointer_q;
        OFF_MSP: rd_raw = master_stack_pointer_q;
        OFF_OPCTL: rd_raw = opctl_q;
        OFF_FIELD: rd_raw = field_val;
        OFF_QLO: rd_raw = gpr_v[pair];
        OFF_QHI: rd_raw = gpr_v[pair | 4'h1];
        OFF_EA: rd_raw = ea;
        OFF_VEC: rd_raw = vec_addr;
        default: rd_raw = REG_RST;
      endcase
  end

  // Bus sequencing: reads take one wait state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE, ST_WR, ST_RDD: st_d = accept ? (HWRITE ? ST_WR : ST_RDW) : ST_IDLE;
      ST_RDW: st_d = ST_RDD;
      default: st_d = ST_IDLE;
    endcase
  end

  assign HREADYOUT = st_q != ST_RDW;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_q;

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_q <= ST_IDLE;
      addr_q <= 8'h00;
      hrdata_q <= REG_RST;
    end
    else
    begin
      st_q <= st_d;
      if (accept)
        addr_q <= HADDR[7:0];
      if (st_q == ST_RDW)
        hrdata_q <= rd_val;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      for (int i = 0; i < 15; i++)
        gpr_q[i] <= REG_RST;
    else if (gw_en && gw_num != A7_NUM)
      gpr_q[gw_num[3:0]] <= gw_val;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      user_stack_pointer_q <= REG_RST;
      interrupt_stack_pointer_q <= REG_RST;
      master_stack_pointer_q <= REG_RST;
    end
    else
    begin
      if (usp_we)
        user_stack_pointer_q <= a7_we ? gw_val : HWDATA;
      if (isp_we)
        interrupt_stack_pointer_q <= a7_we ? gw_val : HWDATA;
      if (msp_we)
        master_stack_pointer_q <= a7_we ? gw_val : HWDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      pc_q <= REG_RST;
    else if (we && addr_q == OFF_PC)
      pc_q <= HWDATA;
    else if (we && addr_q == OFF_PC_ADV)
      pc_q <= pc_q + HWDATA;
  end

  // Control registers writable at supervisor level only
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      vector_table_base_q <= REG_RST;
      source_space_code_q <= 3'h0;
      destination_space_code_q <= 3'h0;
      icache_control_q <= REG_RST;
      icache_op_address_q <= REG_RST;
    end
    else if (sup_we)
    begin
      if (addr_q == OFF_VBR)
        vector_table_base_q <= HWDATA;
      if (addr_q == OFF_SFC)
        source_space_code_q <= HWDATA[2:0];
      if (addr_q == OFF_DFC)
        destination_space_code_q <= HWDATA[2:0];
      if (addr_q == OFF_ICACHE_CONTROL)
        icache_control_q <= HWDATA;
      if (addr_q == OFF_ICACHE_OP_ADDRESS)
        icache_op_address_q <= HWDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      opctl_q <= OPC_RST;
      disp_q <= REG_RST;
      vec_q <= 8'h00;
    end
    else
    begin
      if (we && addr_q == OFF_OPCTL)
        opctl_q <= HWDATA;
      if (we && addr_q == OFF_EA)
        disp_q <= HWDATA;
      if (we && addr_q == OFF_VEC)
        vec_q <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      prog_addr_q <= REG_RST;
      data_addr_q <= REG_RST;
      vec_addr_q <= REG_RST;
      prog_fc_q <= FC_USER_PROG;
      data_fc_q <= FC_USER_DATA;
    end
    else
    begin
      prog_addr_q <= prog_addr;
      data_addr_q <= data_addr;
      vec_addr_q <= vec_addr;
      prog_fc_q <= prog_fc;
      data_fc_q <= data_fc;
    end
  end

  cpr_status u_status (
    .clk(CORE_CLK),
    .rst_n(ARST_N),
    .sr_we(we && addr_q == OFF_SR),
    .sr_wdata(HWDATA[15:0]),
    .add_en(add_hit),
    .add_a(gpr_v[d_idx]),
    .add_b(HWDATA),
    .add_size(op_size),
    .sr_q(processor_status_word),
    .add_res(sum)
  );

  cpr_agu #(.REDUCED(REDUCED)) u_agu (
    .pc(pc_q),
    .disp(disp_q),
    .idx_val(gpr_v[x_idx]),
    .idx_long(opctl_q[OPC_IDX_LONG]),
    .scale(opctl_q[OPC_SCALE_LO +: 2]),
    .vector_table_base(vector_table_base_q),
    .vec(vec_q),
    .sup(sup),
    .alt_en(opctl_q[OPC_ALT]),
    .alt_dst(opctl_q[OPC_ALT_DST]),
    .source_space_code(source_space_code_q),
    .dfc(destination_space_code_q),
    .ea(ea),
    .vec_addr(vec_addr),
    .prog_addr(prog_addr),
    .data_addr(data_addr),
    .prog_fc(prog_fc),
    .data_fc(data_fc)
  );

  assign PROG_ADDR = prog_addr_q;
  assign PROG_FC = prog_fc_q;
  assign DATA_ADDR = data_addr_q;
  assign DATA_FC = data_fc_q;
  assign VECTOR_ADDR = vec_addr_q;
  assign TRACE_MODE = {processor_status_word[SR_T1], processor_status_word[SR_T0]};
  assign SUPERVISOR = sup;
  assign MASTER_MODE = master;
  assign INT_MASK = processor_status_word[SR_IPL_LO +: 3];
  assign COND_FLAGS = processor_status_word[SR_X:0];
  assign ICACHE_CONTROL = icache_control_q;
  assign ICACHE_OP_ADDRESS = icache_op_address_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_rd_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  sequence s_rd_req;
    accept && !HWRITE;
  endsequence

  property p_rd_wait;
    s_rd_req |=> s_rd_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read did not take exactly one wait state");

  property p_vbr_lock;
    we && addr_q == OFF_VBR && !sup |=> $stable(vector_table_base_q);
  endproperty
  a_vbr_lock: assert property (p_vbr_lock) else $error("user write changed vector base");

  property p_a7_user;
    st_q == ST_RDW && addr_q == OFF_A7 && !sup |=> HRDATA == $past(user_stack_pointer_q);
  endproperty
  a_a7_user: assert property (p_a7_user) else $error("user A7 read not user stack");

  property p_addr_byte;
    gpr_hit && addr_q[5] && op_size == SZ_BYTE |-> !gw_en ##1 gpr_v[$past(addr_q[5:2])] == $past(gpr_v[addr_q[5:2]]);
  endproperty
  a_addr_byte: assert property (p_addr_byte) else $error("byte write hit address register");

  property p_pc_adv;
    we && addr_q == OFF_PC_ADV |=> pc_q == $past(pc_q) + $past(HWDATA);
  endproperty
  a_pc_adv: assert property (p_pc_adv) else $error("program counter step wrong");

  property p_narrow;
    REDUCED |-> PROG_ADDR[31:24] == 8'h00 && DATA_ADDR[31:24] == 8'h00 && VECTOR_ADDR[31:24] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("reduced variant drove upper address");

  property p_fc_sup;
    sup |=> PROG_FC == FC_SUP_PROG;
  endproperty
  a_fc_sup: assert property (p_fc_sup) else $error("program space code wrong");

  property p_alt_fc;
    opctl_q[OPC_ALT] && opctl_q[OPC_ALT_DST] |=> DATA_FC == $past(destination_space_code_q);
  endproperty
  a_alt_fc: assert property (p_alt_fc) else $error("alternate destination code not used");
endmodule // cpr_regs

//--- verilog/cpr_status.sv
`timescale 1ns/1ns
module cpr_status
  import cpr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sr_we,
  input wire logic [15:0] sr_wdata,
  input wire logic add_en,
  input wire logic [31:0] add_a,
  input wire logic [31:0] add_b,
  input wire cpr_size_t add_size,
  output logic [15:0] sr_q,
  output logic [31:0] add_res
);
  logic [15:0] sr_d;
  logic [5:0] sh;
  logic [31:0] a_s;
  logic [31:0] b_s;
  logic [32:0] sum;
  logic ov;
  logic zr;

  // Operands aligned to bit 31 so flags read the same for every size
  assign sh = (add_size == SZ_BYTE) ? 6'h18 : (add_size == SZ_WORD) ? 6'h10 : 6'h00;
  assign a_s = add_a << sh;
  assign b_s = add_b << sh;
  assign sum = {1'b0, a_s} + {1'b0, b_s};
  assign ov = (a_s[31] == b_s[31]) && (sum[31] != a_s[31]);
  assign zr = sum[31:0] == 32'h0000_0000;
  assign add_res = sum[31:0] >> sh;

  assign sr_d = !sr_we ? (add_en ? {sr_q[15:5], sum[32], sum[31], zr, ov, sum[32]} : sr_q)
    : sr_q[SR_S] ? (sr_wdata & SR_IMPL)
    : {sr_q[15:8], sr_wdata[7:0] & SR_IMPL[7:0]};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sr_q <= SR_RST;
    else
      sr_q <= sr_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_user_ccr;
    sr_we && !sr_q[SR_S] |=> sr_q[15:8] == $past(sr_q[15:8]) && sr_q[7:0] == ($past(sr_wdata[7:0]) & SR_IMPL[7:0]);
  endproperty
  a_user_ccr: assert property (p_user_ccr) else $error("user status write touched upper byte");

  property p_sup_full;
    sr_we && sr_q[SR_S] |=> sr_q == ($past(sr_wdata) & SR_IMPL);
  endproperty
  a_sup_full: assert property (p_sup_full) else $error("supervisor status write lost");

  property p_zero_flag;
    add_en && !sr_we && zr |=> sr_q[SR_Z] && $stable(sr_q[15:5]);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag not set by sum");
endmodule // cpr_status
